// >>> core_flags_pkg.sv
// Shared constants, types and layouts for the flag register and bank decoder
package core_flags_pkg;

  localparam int DATA_W = 8;
  localparam int OFFS_W = 7;
  localparam int BANK_W = 5;
  localparam int ADDR_W = 12;
  localparam int GPR_PER_BANK = 80;
  localparam int COMMON_BYTES = 16;
  localparam int CORE_REGS = 12;

  // Core register offsets, mirrored in every bank
  localparam logic [6:0] OFF_IND0 = 7'h00;
  localparam logic [6:0] OFF_IND1 = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_FLAGS = 7'h03;
  localparam logic [6:0] OFF_PTR0L = 7'h04;
  localparam logic [6:0] OFF_PTR0H = 7'h05;
  localparam logic [6:0] OFF_PTR1L = 7'h06;
  localparam logic [6:0] OFF_PTR1H = 7'h07;
  localparam logic [6:0] OFF_BANKSEL = 7'h08;
  localparam logic [6:0] OFF_WACC = 7'h09;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
  localparam logic [6:0] OFF_INTCTL = 7'h0B;

  // Region bounds within a bank
  localparam logic [6:0] PERIPH_LO = 7'h0C;
  localparam logic [6:0] PERIPH_HI = 7'h1F;
  localparam logic [6:0] GPR_LO = 7'h20;
  localparam logic [6:0] GPR_HI = 7'h6F;
  localparam logic [6:0] COMMON_LO = 7'h70;

  // Flag bit positions in the readable register
  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_SLEPT = 3;
  localparam int BIT_TO = 4;
  localparam int NIB_MSB = 4;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  typedef struct packed {
    logic to;
    logic slept;
    logic z;
    logic dc;
    logic c;
  } flags_t;

  localparam flags_t FLAGS_POR = '{to: 1'b1, slept: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h2,
    OP_ROR = 3'h3,
    OP_ROL = 3'h4,
    OP_PASS = 3'h5
  } alu_op_t;

  typedef enum logic [1:0] {
    RGN_CORE = 2'h0,
    RGN_PERIPH = 2'h1,
    RGN_GPR = 2'h3,
    RGN_COMMON = 2'h2
  } region_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect;
    logic [6:0] offset;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    alu_op_t op;
    logic wb;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] bank;
    logic [6:0] offset;
    logic [7:0] wdata;
  } periph_req_t;

endpackage

// >>> flag_alu.sv
// Combinational adder, rotator and flag generator
`timescale 1ns/1ns
module flag_alu
  import core_flags_pkg::*;
(
  input wire core_flags_pkg::alu_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic z_out,
  output logic dc_out,
  output logic c_out,
  output logic upd_z_out,
  output logic upd_carry_out,
  output logic upd_dc_out
);
  import core_flags_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb
  begin
    sum = 9'h0_00;
    nib = 5'h0_0;
    result_out = b_in;
    c_out = carry_in;
    dc_out = 1'b0;
    upd_z_out = 1'b0;
    upd_carry_out = 1'b0;
    upd_dc_out = 1'b0;
    case (op_in)
      OP_ADD:
      begin
        sum = {1'b0, a_in} + {1'b0, b_in};
        nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        result_out = sum[7:0];
        c_out = sum[8];
        dc_out = nib[NIB_MSB];
        {upd_z_out, upd_carry_out, upd_dc_out} = 3'h7;
      end
      OP_SUB:
      begin
        // b minus a, done as b plus the two's complement of a
        sum = {1'b0, b_in} + {1'b0, ~a_in} + 9'h0_01;
        nib = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h0_1;
        result_out = sum[7:0];
        c_out = sum[8];
        dc_out = nib[NIB_MSB];
        {upd_z_out, upd_carry_out, upd_dc_out} = 3'h7;
      end
      OP_ROR:
      begin
        result_out = {carry_in, b_in[7:1]};
        c_out = b_in[0];
        upd_carry_out = 1'b1;
      end
      OP_ROL:
      begin
        result_out = {b_in[6:0], carry_in};
        c_out = b_in[7];
        upd_carry_out = 1'b1;
      end
      OP_PASS:
      begin
        result_out = a_in;
        upd_z_out = 1'b1;
      end
      default:
      begin
        result_out = b_in;
      end
    endcase
    z_out = (result_out == BYTE_ZERO);
  end

endmodule

// >>> core_status_flags_bank_map.sv
// Flag register, core registers and banked data memory decoder
`timescale 1ns/1ns
module core_status_flags_bank_map #(
  parameter int GPR_BANKS = 32
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic por_in,
  input wire logic kick_in,
  input wire logic sleep_in,
  input wire logic timer_lapse_in,
  input wire core_flags_pkg::mem_req_t mem_in,
  input wire core_flags_pkg::alu_req_t alu_in,
  input wire logic [7:0] periph_rdata_in,
  output core_flags_pkg::periph_req_t periph_out,
  output logic [7:0] rdata_out,
  output logic rd_valid_out,
  output logic [7:0] result_out,
  output logic result_valid_out,
  output logic [7:0] status_out,
  output core_flags_pkg::flags_t flags_out,
  output logic [4:0] bank_out
);
  import core_flags_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  typedef struct packed {
    flags_t flags;
    logic [CORE_REGS-1:0][7:0] core;
    logic [7:0] rdata;
    logic rd_valid;
    logic [7:0] result;
    logic res_valid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // RAM stays out of the state struct; copying it every cycle would cost too much
  logic [7:0] gpr_mem [GPR_BANKS*GPR_PER_BANK];
  logic [7:0] common_mem [COMMON_BYTES];

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Bounds are inclusive; every offset above general RAM reaches the shared window
  function automatic region_t region_of(input logic [6:0] off);
    if (off < PERIPH_LO)
      return RGN_CORE;
    else if (off <= PERIPH_HI)
      return RGN_PERIPH;
    else if (off <= GPR_HI)
      return RGN_GPR;
    else
      return RGN_COMMON;
  endfunction

  // Linear index into the per-bank RAM; callers check the region first
  function automatic int gpr_index(input logic [4:0] bank, input logic [6:0] off);
    return int'(bank) * GPR_PER_BANK + int'(off - GPR_LO);
  endfunction

  function automatic logic [7:0] pack_status(input flags_t f);
    logic [7:0] v;
    // Unused bits stay low here so every reader sees zeros
    v = BYTE_ZERO;
    v[BIT_TO] = f.to;
    v[BIT_SLEPT] = f.slept;
    v[BIT_Z] = f.z;
    v[BIT_DC] = f.dc;
    v[BIT_C] = f.c;
    return v;
  endfunction

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  logic [4:0] acc_bank;
  logic [6:0] acc_off;
  region_t acc_rgn;
  logic gpr_hit;
  logic [7:0] wr_data;

  // Indirect accesses carry a full address; direct ones use the bank selector
  assign acc_bank = mem_in.indirect ? mem_in.addr[11:7] : st_r.core[OFF_BANKSEL][4:0];
  assign acc_off = mem_in.indirect ? mem_in.addr[6:0] : mem_in.offset;
  assign acc_rgn = region_of(acc_off);
  assign gpr_hit = (acc_rgn == RGN_GPR) && (int'(acc_bank) < GPR_BANKS);

  // ----------------------------------------
  // Access qualification
  // ----------------------------------------
  logic wr_en;

  // Writes seen while reset is held are dropped, so a retained register stays intact
  assign wr_en = mem_in.wr && !srst_in;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic alu_go;

  // Operations offered while reset is held are dropped as well
  assign alu_go = alu_in.valid && (alu_in.op != OP_NONE) && !srst_in;

  // Rotates take the carry as it stood before this cycle

  flag_alu u_alu (
    .op_in(alu_go ? alu_in.op : OP_NONE),
    .a_in(alu_in.a),
    .b_in(alu_in.b),
    .carry_in(st_r.flags.c),
    .result_out(alu_res),
    .z_out(alu_z),
    .dc_out(alu_dc),
    .c_out(alu_c),
    .upd_z_out(upd_z),
    .upd_carry_out(upd_c),
    .upd_dc_out(upd_dc)
  );

  // A write-back operation stores the ALU result instead of the bus data
  assign wr_data = (alu_go && alu_in.wb) ? alu_res : mem_in.wdata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    // Valids and read data follow the request each cycle; everything else holds unless written
    st_nxt = st_r;
    st_nxt.rd_valid = mem_in.rd;
    st_nxt.res_valid = alu_go;
    if (alu_go)
      st_nxt.result = alu_res;

    // Plain register writes
    if (wr_en && (acc_rgn == RGN_CORE))
    begin
      if (acc_off == OFF_FLAGS)
      begin
        // Power flags cannot be written
        st_nxt.flags.z = wr_data[BIT_Z];
        st_nxt.flags.dc = wr_data[BIT_DC];
        st_nxt.flags.c = wr_data[BIT_C];
      end
      else if ((acc_off != OFF_IND0) && (acc_off != OFF_IND1))
        st_nxt.core[acc_off[3:0]] = wr_data;
    end

    // ALU flag updates override a write to the same bits
    if (upd_z)
      st_nxt.flags.z = alu_z;
    if (upd_dc)
      st_nxt.flags.dc = alu_dc;
    if (upd_c)
      st_nxt.flags.c = alu_c;

    // Kick or sleep sets the lapse flag and wins over a coincident timeout
    if (kick_in || sleep_in)
      st_nxt.flags.to = 1'b1;
    else if (timer_lapse_in)
      st_nxt.flags.to = 1'b0;
    if (kick_in)
      st_nxt.flags.slept = 1'b1;
    else if (sleep_in)
      st_nxt.flags.slept = 1'b0;

    // Read path
    // A read beside a write to the same place returns the old value
    st_nxt.rdata = BYTE_ZERO;
    if (mem_in.rd)
    begin
      case (acc_rgn)
        RGN_CORE:
        begin
          if (acc_off == OFF_FLAGS)
            st_nxt.rdata = pack_status(st_r.flags);
          else if ((acc_off != OFF_IND0) && (acc_off != OFF_IND1))
            st_nxt.rdata = st_r.core[acc_off[3:0]];
        end
        RGN_PERIPH:
          st_nxt.rdata = periph_rdata_in;
        RGN_GPR:
        begin
          if (gpr_hit)
            st_nxt.rdata = gpr_mem[gpr_index(acc_bank, acc_off)];
        end
        RGN_COMMON:
          st_nxt.rdata = common_mem[acc_off[3:0]];
        default:
          st_nxt.rdata = BYTE_ZERO;
      endcase
    end

    // Only a power-on or brown-out reset clears the arithmetic flags
    if (srst_in)
    begin
      st_nxt.rd_valid = 1'b0;
      st_nxt.res_valid = 1'b0;
      st_nxt.rdata = BYTE_ZERO;
      if (por_in)
      begin
        st_nxt.flags = FLAGS_POR;
        st_nxt.core = '0;
        st_nxt.result = BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // RAM arrays, not cleared by reset
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (wr_en)
    begin
      if (gpr_hit)
        gpr_mem[gpr_index(acc_bank, acc_off)] <= wr_data;
      if (acc_rgn == RGN_COMMON)
        common_mem[acc_off[3:0]] <= wr_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb
  begin
    // Strobes are combinational so the region answers within the access cycle
    periph_out.rd = mem_in.rd && (acc_rgn == RGN_PERIPH);
    periph_out.wr = wr_en && (acc_rgn == RGN_PERIPH);
    periph_out.bank = acc_bank;
    periph_out.offset = acc_off;
    periph_out.wdata = wr_data;
  end

  assign rdata_out = st_r.rdata;
  assign rd_valid_out = st_r.rd_valid;
  assign result_out = st_r.result;
  assign result_valid_out = st_r.res_valid;
  assign status_out = pack_status(st_r.flags);
  assign flags_out = st_r.flags;
  assign bank_out = st_r.core[OFF_BANKSEL][4:0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // Reads that must return zero: the indirect ports and RAM beyond the last bank
  logic unimpl_rd;
  logic flag_rd;
  logic plain_flag_wr;
  assign unimpl_rd = mem_in.rd && (((acc_rgn == RGN_GPR) && !gpr_hit)
    || ((acc_rgn == RGN_CORE) && ((acc_off == OFF_IND0) || (acc_off == OFF_IND1))));
  assign flag_rd = mem_in.rd && (acc_off == OFF_FLAGS);
  // No operation and no power event, so the written bits must land as given
  assign plain_flag_wr = mem_in.wr && (acc_off == OFF_FLAGS) && !alu_go
    && !kick_in && !sleep_in && !timer_lapse_in;

  a_upper_bits_zero: assert property (flag_rd |=> rdata_out[7:5] == 3'h0)
    else $error("flag register upper bits not zero");
  a_lapse_sets_to: assert property (kick_in || sleep_in |=> flags_out.to)
    else $error("kick or sleep did not set lapse flag");
  a_lapse_clears_to: assert property (timer_lapse_in && !kick_in && !sleep_in |=> !flags_out.to)
    else $error("timeout did not clear lapse flag");
  a_kick_sets_both: assert property (kick_in |=> flags_out.to && flags_out.slept)
    else $error("kick did not set power flags");
  a_sleep_clears_slept: assert property (sleep_in && !kick_in |=> !flags_out.slept && flags_out.to)
    else $error("sleep did not update power flags");
  a_zero_tracks: assert property (alu_go && (alu_in.op inside {OP_ADD, OP_SUB, OP_PASS})
    |=> result_valid_out && (flags_out.z == (result_out == BYTE_ZERO)))
    else $error("zero flag mismatch");
  a_add_carries: assert property (alu_go && (alu_in.op == OP_ADD)
    |=> {flags_out.c, result_out} == {1'b0, $past(alu_in.a)} + {1'b0, $past(alu_in.b)}
    && flags_out.dc == (({1'b0, $past(alu_in.a[3:0])} + {1'b0, $past(alu_in.b[3:0])}) > 5'h0_F))
    else $error("add carry flags wrong");
  a_sub_borrow: assert property (alu_go && (alu_in.op == OP_SUB)
    |=> flags_out.c == ($past(alu_in.b) >= $past(alu_in.a))
    && flags_out.dc == ($past(alu_in.b[3:0]) >= $past(alu_in.a[3:0])))
    else $error("subtract borrow flags wrong");
  a_rotate_out: assert property (alu_go && (alu_in.op == OP_ROR) |=> flags_out.c == $past(alu_in.b[0]))
    else $error("rotate carry wrong");
  a_rotate_left: assert property (alu_go && (alu_in.op == OP_ROL) |=> flags_out.c == $past(alu_in.b[7]))
    else $error("rotate left carry wrong");
  a_por_values: assert property (disable iff (1'b0) srst_in && por_in |=> flags_out == FLAGS_POR)
    else $error("power-on flag values wrong");
  a_unimpl_zero: assert property (unimpl_rd |=> rd_valid_out && (rdata_out == BYTE_ZERO))
    else $error("unimplemented read not zero");
  a_dest_suppress: assert property (alu_go && (alu_in.op == OP_ADD) && mem_in.wr && !mem_in.indirect
    && (mem_in.offset == OFF_FLAGS)
    |=> flags_out.c == (({1'b0, $past(alu_in.a)} + {1'b0, $past(alu_in.b)}) > 9'h0_FF))
    else $error("flag write not suppressed");
  a_plain_flag_wr: assert property (plain_flag_wr |=> (flags_out.z == $past(mem_in.wdata[BIT_Z]))
    && (flags_out.dc == $past(mem_in.wdata[BIT_DC])) && (flags_out.c == $past(mem_in.wdata[BIT_C]))
    && (flags_out.to == $past(flags_out.to)) && (flags_out.slept == $past(flags_out.slept)))
    else $error("plain flag write wrong");
  a_bank_select: assert property (mem_in.wr && !mem_in.indirect && !alu_go
    && (mem_in.offset == OFF_BANKSEL) |=> bank_out == $past(mem_in.wdata[4:0]))
    else $error("bank selector not loaded");
  a_periph_decode: assert property (mem_in.rd && !mem_in.indirect
    && (mem_in.offset inside {[PERIPH_LO:PERIPH_HI]}) |-> periph_out.rd && (periph_out.bank == bank_out))
    else $error("peripheral region not decoded");

  c_add_op: cover property (alu_go && (alu_in.op == OP_ADD) ##1 flags_out.dc);
  c_common_rd: cover property (mem_in.rd && (acc_rgn == RGN_COMMON));
  c_sleep_then_kick: cover property (sleep_in ##[1:4] kick_in);
  c_flag_dest_add: cover property (alu_go && (alu_in.op == OP_ADD) && mem_in.wr && (acc_off == OFF_FLAGS));

endmodule

// >>> core_periph_model.sv
// Peripheral register region model seen by the bank decoder
`timescale 1ns/1ns
module core_periph_model
  import core_flags_pkg::*;
(
  input wire core_flags_pkg::periph_req_t req_in,
  output logic [7:0] rdata_out
);
  logic [7:0] pattern;
  // Contents differ across banks whose low three bits differ, so a wrong low bank bit shows in the data
  assign pattern = {req_in.bank[2:0], req_in.offset[4:0]};
  // Outside a read the bus shows the inverse so a stale sample never matches
  assign rdata_out = req_in.rd ? pattern : ~pattern;
endmodule

// >>> tb_top.sv
// Self-checking bench for the flag register and bank decoder
`timescale 1ns/1ns
module tb_top;
  import core_flags_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic por_in = 1'b1;
  logic kick_in = 1'b0;
  logic sleep_in = 1'b0;
  logic timer_lapse_in = 1'b0;
  mem_req_t mem_in = '0;
  alu_req_t alu_in = '0;
  logic [7:0] periph_rdata_in;
  periph_req_t periph_out;
  logic [7:0] rdata_out, result_out, status_out;
  logic rd_valid_out, result_valid_out;
  flags_t flags_out;
  flags_t exp_f;
  logic [4:0] bank_out;
  int fails = 0;
  int comparisons = 0;

  core_status_flags_bank_map #(.GPR_BANKS(32)) i_core_status_flags_bank_map (.clk_in(clk_in), .srst_in(srst_in),
    .por_in(por_in), .kick_in(kick_in), .sleep_in(sleep_in), .timer_lapse_in(timer_lapse_in), .mem_in(mem_in),
    .alu_in(alu_in), .periph_rdata_in(periph_rdata_in), .periph_out(periph_out), .rdata_out(rdata_out),
    .rd_valid_out(rd_valid_out), .result_out(result_out), .result_valid_out(result_valid_out),
    .status_out(status_out), .flags_out(flags_out), .bank_out(bank_out));
  core_periph_model i_core_periph_model (.req_in(periph_out), .rdata_out(periph_rdata_in));

  always #10 clk_in = ~clk_in;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task acc(input logic w, input logic ind, input logic [11:0] adr, input logic [7:0] wd, input logic [7:0] exp);
    @(posedge clk_in);
    #1;
    mem_in = '{rd: ~w, wr: w, indirect: ind, offset: adr[6:0], addr: adr, wdata: wd};
    @(posedge clk_in);
    #1;
    mem_in = '0;
    if (!w)
      check({rd_valid_out, rdata_out}, {1'b1, exp});
  endtask

  task pulse(input logic [2:0] k);
    @(posedge clk_in);
    #1;
    {kick_in, sleep_in, timer_lapse_in} = k;
    @(posedge clk_in);
    #1;
    {kick_in, sleep_in, timer_lapse_in} = 3'b000;
  endtask

  task alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic wf, input logic [7:0] wd);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    flags_t f;
    f = exp_f;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    r = a;
    if (wf)
      {f.z, f.dc, f.c} = wd[2:0];
    if (op == OP_SUB)
    begin
      s = {1'b0, b} + {1'b0, ~a} + 9'h001;
      n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
    end
    if (op == OP_ADD || op == OP_SUB)
    begin
      r = s[7:0];
      f.c = s[8];
      f.dc = n[4];
    end
    if (op == OP_ROR)
      {r, f.c} = {exp_f.c, b};
    if (op == OP_ROL)
      {f.c, r} = {b, exp_f.c};
    if (op != OP_ROR && op != OP_ROL)
      f.z = (r == 8'h00);
    @(posedge clk_in);
    #1;
    alu_in = '{valid: 1'b1, op: op, wb: 1'b0, a: a, b: b};
    if (wf)
      mem_in = '{rd: 1'b0, wr: 1'b1, indirect: 1'b0, offset: OFF_FLAGS, addr: 12'h000, wdata: wd};
    @(posedge clk_in);
    #1;
    alu_in = '0;
    mem_in = '0;
    check({result_valid_out, result_out}, {1'b1, r});
    check(status_out, {3'b000, f});
    exp_f = f;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    por_in = 1'b0;
    acc(0, 0, 12'h003, 8'h00, 8'h18);
    acc(1, 0, 12'h003, 8'hFF, 8'h00);
    acc(0, 0, 12'h003, 8'h00, 8'h1F);
    check(status_out, 8'h1F);
    pulse(3'b010);
    acc(0, 0, 12'h003, 8'h00, 8'h17);
    pulse(3'b001);
    acc(0, 0, 12'h003, 8'h00, 8'h07);
    pulse(3'b011);
    acc(0, 0, 12'h003, 8'h00, 8'h17);
    pulse(3'b010);
    pulse(3'b100);
    acc(0, 0, 12'h003, 8'h00, 8'h1F);
    exp_f = flags_t'(5'h1F);
    alu(OP_ADD, 8'h08, 8'h08, 0, 8'h00);
    alu(OP_ADD, 8'hFF, 8'h01, 0, 8'h00);
    alu(OP_SUB, 8'h01, 8'h00, 0, 8'h00);
    alu(OP_SUB, 8'h01, 8'h01, 0, 8'h00);
    alu(OP_ROR, 8'h00, 8'h01, 0, 8'h00);
    alu(OP_ROL, 8'h00, 8'h40, 0, 8'h00);
    alu(OP_PASS, 8'h00, 8'h00, 0, 8'h00);
    alu(OP_ADD, 8'h01, 8'h01, 1, 8'hE7);
    acc(0, 0, 12'h003, 8'h00, {3'b000, exp_f});
    acc(1, 0, 12'h008, 8'h02, 8'h00);
    check(bank_out, 5'h02);
    acc(1, 0, 12'h020, 8'h11, 8'h00);
    acc(1, 0, 12'h070, 8'hAA, 8'h00);
    acc(1, 0, 12'h009, 8'h5A, 8'h00);
    acc(1, 0, 12'h008, 8'h05, 8'h00);
    acc(1, 0, 12'h020, 8'h22, 8'h00);
    acc(0, 0, 12'h070, 8'h00, 8'hAA);
    acc(0, 1, 12'hF70, 8'h00, 8'hAA);
    acc(0, 0, 12'h009, 8'h00, 8'h5A);
    acc(0, 1, 12'h188, 8'h00, 8'h05);
    acc(0, 1, 12'h120, 8'h00, 8'h11);
    acc(0, 0, 12'h020, 8'h00, 8'h22);
    acc(1, 1, 12'h000, 8'h3C, 8'h00);
    acc(0, 1, 12'h000, 8'h00, 8'h00);
    @(posedge clk_in);
    #1;
    mem_in = '{rd: 1'b1, wr: 1'b0, indirect: 1'b0, offset: 7'h1F, addr: 12'h000, wdata: 8'h00};
    #1;
    check({periph_out.rd, periph_out.bank, periph_out.offset}, {1'b1, 5'h05, 7'h1F});
    @(posedge clk_in);
    #1;
    mem_in = '0;
    check(rdata_out, 8'hBF);
    // A write-back operation sends the ALU sum, not the bus data, to the region
    @(posedge clk_in);
    #1;
    mem_in = '{rd: 1'b0, wr: 1'b1, indirect: 1'b0, offset: 7'h0C, addr: 12'h000, wdata: 8'h00};
    alu_in = '{valid: 1'b1, op: OP_ADD, wb: 1'b1, a: 8'h03, b: 8'h04};
    #1;
    check({periph_out.rd, periph_out.wr, periph_out.wdata}, {2'b01, 8'h07});
    @(posedge clk_in);
    #1;
    mem_in = '0;
    alu_in = '0;
    acc(1, 0, 12'h003, 8'h05, 8'h00);
    srst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    acc(0, 0, 12'h003, 8'h00, 8'h1D);
    check(bank_out, 5'h05);
    srst_in = 1'b1;
    por_in = 1'b1;
    @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    por_in = 1'b0;
    acc(0, 0, 12'h003, 8'h00, 8'h18);
    check(flags_out, FLAGS_POR);
    finish_test;
  end

  // Tests need under a hundred cycles; this margin cuts a hang short
  initial
  begin
    repeat (3000) @(posedge clk_in);
    fails++;
    finish_test;
  end
endmodule
